// *** uop_pkg.sv ***
/*
  Shared constants for the on-the-go port control block: the register offsets
  on the APB bus, the field positions and the values after reset.
  Assumes a 32-bit APB bus and the byte offsets given below.
*/
package uop_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int          APB_AW        = 12;         // byte address width
  localparam int          APB_DW        = 32;         // data width

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] OFS_CTRL1     = 12'h000;    // speed, suspend, format, pin irq
  localparam logic [11:0] OFS_SFR1      = 12'h004;    // pin override
  localparam logic [11:0] OFS_SFR2      = 12'h008;    // interrupt drive type
  localparam logic [11:0] OFS_STATUS    = 12'h00c;    // live state, read only
  localparam logic [11:0] OFS_MGMT      = 12'h010;    // management data line pull

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int          BIT_SPEED     = 0;          // ctrl1: full speed when 1
  localparam int          BIT_SUSPEND   = 1;          // ctrl1: suspend when 1
  localparam int          BIT_FORMAT    = 2;          // ctrl1: data/zero format when 1
  localparam int          BIT_PININT    = 5;          // ctrl1: direction pin irq enable
  localparam int          BIT_OVERRIDE  = 1;          // sfr1: registers govern when 1
  localparam int          BIT_IRQPP     = 1;          // sfr2: push-pull when 1
  localparam int          BIT_MGMTPULL  = 0;          // mgmt: pull data line low
  localparam int          ST_FULLSPD    = 0;          // status: effective speed
  localparam int          ST_SUSP       = 1;          // status: effective suspend
  localparam int          ST_RXMODE     = 2;          // status: receive mode
  localparam int          ST_DIFFRX     = 3;          // status: receiver output
  localparam int          ST_IRQ        = 4;          // status: interrupt pending
  localparam int          ST_SCL        = 5;          // status: serial clock level

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic        RST_SPEED     = 1'b0;
  localparam logic        RST_SUSPEND   = 1'b0;
  localparam logic        RST_FORMAT    = 1'b0;
  localparam logic        RST_PININT    = 1'b0;
  localparam logic        RST_OVERRIDE  = 1'b0;
  localparam logic        RST_IRQPP     = 1'b0;
  localparam logic        RST_MGMTPULL  = 1'b0;

  // pin driver slots
  localparam int          NUM_PINS      = 3;
  localparam int          PIN_INT       = 0;          // dedicated interrupt pin
  localparam int          PIN_DIR       = 1;          // direction pin as interrupt
  localparam int          PIN_SDA       = 2;          // management data line

endpackage

// *** uop_pin_drv.sv ***
/*
  One active-low output pin that can be driven push-pull or open-drain.
  Assumes the caller resolves the wire level from pinOut and pinOe.
*/
module uop_pin_drv
  import uop_pkg::*;
(
  input  wire logic clk,       // system clock
  input  wire logic arst,      // asynchronous reset, high
  input  wire logic enable,    // pin may be driven at all
  input  wire logic pushPull,  // 1 push-pull, 0 open-drain
  input  wire logic assertReq, // request the active (low) level
  output logic      pinOut,    // driven level
  output logic      pinOe      // drive enable
);

  logic outNext;               // next driven level
  logic oeNext;                // next drive enable

  // open-drain never drives high, so its level is always zero
  assign outNext = enable & pushPull & ~assertReq;
  assign oeNext  = enable & (pushPull | assertReq);

  // registered so the pins never glitch on decode
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end else begin
      pinOut <= outNext;
      pinOe  <= oeNext;
    end
  end

  a_od_low_only: assert property (@(posedge clk) disable iff (arst)
    enable && !pushPull |=> !pinOut && (pinOe == $past(assertReq)))
    else $error("open-drain pin drove high or wrong enable");

  a_pp_drives: assert property (@(posedge clk) disable iff (arst)
    enable && pushPull |=> pinOe && (pinOut == !$past(assertReq)))
    else $error("push-pull pin not driven correctly");

endmodule

// *** uop_port_ctrl.sv ***
/*
  System-side mode and direction control of a full/low-speed on-the-go
  transceiver, with its control bits reached over APB.
  Assumes all pin inputs are synchronous to clk and that the testbench
  resolves two-way wires from the out/oe pairs.
*/
// Local design decisions: the register offsets and the APB interface to the registers.

// Summary of operation
// - zero/minus pin input on 0, output on 1
// - format bit selects system pin functions
// - direction 0 transmit, 1 receive
// - direction pin reports interrupts in suspend
// - pin interrupt enable bit gates that
// - drive-type bit selects push-pull or open-drain
// - receiver output follows D+ versus D- (here in receive mode only; in transmit it holds its last value)
// - receiver output low while suspended
// - override bit makes rate, suspend pins ignored
// - speed bit rules when override set
// - suspend bit rules when override set
// - management data line only pulled low
// - dedicated interrupt output is active low
// - reset pin resets asynchronously
module uop_port_ctrl
  import uop_pkg::*;
(
  input  wire logic              clk,            // 40 MHz system clock
  input  wire logic              rst,            // asynchronous reset, high
  input  wire logic              resetPinN,      // device reset pin, low
  input  wire logic              psel,           // apb select
  input  wire logic              penable,        // apb access phase
  input  wire logic              pwrite,         // apb write
  input  wire logic [APB_AW-1:0] paddr,          // apb byte address
  input  wire logic [APB_DW-1:0] pwdata,         // apb write data
  output logic      [APB_DW-1:0] prdata,         // apb read data
  output logic                   pready,         // apb ready
  output logic                   pslverr,        // apb error, unmapped
  input  wire logic              dirPinIn,       // direction pin level
  output logic                   dirPinOut,      // direction pin as irq
  output logic                   dirPinOe,       // direction pin drive
  input  wire logic              sysDataPlusIn,  // system data/plus in
  output logic                   sysDataPlusOut, // system data/plus out
  output logic                   sysDataPlusOe,  // system data/plus drive
  input  wire logic              sysZeroMinusIn, // system zero/minus in
  output logic                   sysZeroMinusOut,// system zero/minus out
  output logic                   sysZeroMinusOe, // system zero/minus drive
  input  wire logic              usbDpIn,        // usb D+ level
  output logic                   usbDpOut,       // usb D+ drive level
  output logic                   usbDpOe,        // usb D+ drive
  input  wire logic              usbDmIn,        // usb D- level
  output logic                   usbDmOut,       // usb D- drive level
  output logic                   usbDmOe,        // usb D- drive
  output logic                   diffRxOut,      // differential receiver
  output logic                   plusLineCopy,   // copy of D+
  output logic                   minusLineCopy,  // copy of D-
  input  wire logic              rateSelPin,     // 1 full, 0 low speed
  input  wire logic              lowpowerPin,    // suspend pin, high
  input  wire logic              irqPending,     // interrupt conditions
  output logic                   intPinOut,      // interrupt pin level
  output logic                   intPinOe,       // interrupt pin drive
  input  wire logic              mgmtSclIn,      // serial clock, input only
  output logic                   mgmtSdaOut,     // serial data level
  output logic                   mgmtSdaOe,      // serial data pull
  output logic                   fullSpeed,      // effective speed
  output logic                   suspended       // effective suspend
);

  ////////////////////////////////////////////////////////////////////////////
  // reset merge

  logic arst;                                    // combined async reset
  // the pin reset acts without the clock, like the system reset
  assign arst = rst | ~resetPinN;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  logic speed_reg, susp_reg, fmt_reg, pinInt_reg;  // control 1 fields
  logic ovr_reg;                                   // override field
  logic irqPp_reg;                                 // drive type field
  logic mgmtPull_reg;                              // data line pull
  logic ready_reg, err_reg;                        // bus answer
  logic [APB_DW-1:0] rdata_reg;                    // read data

  logic access, takeEdge, wrEn;                    // phase decodes
  logic selCtrl1, selSfr1, selSfr2, selStatus, selMgmt, mapped;
  logic [APB_DW-1:0] rdMux;                        // read selection
  logic [APB_DW-1:0] statusWord;                   // live state word

  // one wait state: ready rises in the second access cycle
  assign access    = psel & penable;
  assign takeEdge  = access & ready_reg;
  assign wrEn      = takeEdge & pwrite;
  assign selCtrl1  = (paddr == OFS_CTRL1);
  assign selSfr1   = (paddr == OFS_SFR1);
  assign selSfr2   = (paddr == OFS_SFR2);
  assign selStatus = (paddr == OFS_STATUS);
  assign selMgmt   = (paddr == OFS_MGMT);
  assign mapped    = selCtrl1 | selSfr1 | selSfr2 | selStatus | selMgmt;

  // read mux, unmapped reads return zero
  always_comb begin
    rdMux = '0;
    if (selCtrl1) begin
      rdMux[BIT_SPEED]   = speed_reg;
      rdMux[BIT_SUSPEND] = susp_reg;
      rdMux[BIT_FORMAT]  = fmt_reg;
      rdMux[BIT_PININT]  = pinInt_reg;
    end
    if (selSfr1) rdMux[BIT_OVERRIDE] = ovr_reg;
    if (selSfr2) rdMux[BIT_IRQPP] = irqPp_reg;
    if (selMgmt) rdMux[BIT_MGMTPULL] = mgmtPull_reg;
    if (selStatus) rdMux = statusWord;
  end

  // bus answer, registered so outputs come from flops
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ready_reg <= access & ~ready_reg;
      err_reg   <= access & ~ready_reg & ~mapped;
      if (access & ~ready_reg) rdata_reg <= rdMux;
    end
  end

  // control fields, written only at the completing edge
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      speed_reg    <= RST_SPEED;
      susp_reg     <= RST_SUSPEND;
      fmt_reg      <= RST_FORMAT;
      pinInt_reg   <= RST_PININT;
      ovr_reg      <= RST_OVERRIDE;
      irqPp_reg    <= RST_IRQPP;
      mgmtPull_reg <= RST_MGMTPULL;
    end else if (wrEn) begin
      if (selCtrl1) begin
        speed_reg  <= pwdata[BIT_SPEED];
        susp_reg   <= pwdata[BIT_SUSPEND];
        fmt_reg    <= pwdata[BIT_FORMAT];
        pinInt_reg <= pwdata[BIT_PININT];
      end
      if (selSfr1) ovr_reg <= pwdata[BIT_OVERRIDE];
      if (selSfr2) irqPp_reg <= pwdata[BIT_IRQPP];
      if (selMgmt) mgmtPull_reg <= pwdata[BIT_MGMTPULL];
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = ready_reg;
  assign pslverr = err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // speed and suspend selection

  logic speedEff, suspEff;                       // governing values
  // the system sets the rate and suspend pins; with override they are ignored
  assign speedEff = ovr_reg ? speed_reg : rateSelPin;
  assign suspEff  = ovr_reg ? susp_reg  : lowpowerPin;

  ////////////////////////////////////////////////////////////////////////////
  // direction and data path

  logic dirAsIrq, rxMode;                        // direction pin use
  logic diffRxNext;                              // receiver next value
  logic seZero;                                  // both usb lines low
  logic txDp, txDm;                              // transmit line values
  logic sysPlusNext, sysMinusNext;               // receive pin values

  // the pin is our output only in suspend with its irq enabled
  assign dirAsIrq = suspEff & pinInt_reg;
  // while it serves as irq, the transceiver stays out of transmit
  assign rxMode   = dirAsIrq | dirPinIn;
  assign seZero   = ~usbDpIn & ~usbDmIn;

  // receiver holds its last value on single-ended states
  assign diffRxNext = suspEff ? 1'b0 :
                      (rxMode & usbDpIn & ~usbDmIn) ? 1'b1 :
                      (rxMode & ~usbDpIn & usbDmIn) ? 1'b0 :
                      diffRxOut;

  // transmit: data/zero format or straight plus/minus copies
  assign txDp = fmt_reg ? (sysDataPlusIn & ~sysZeroMinusIn) : sysDataPlusIn;
  assign txDm = fmt_reg ? (~sysDataPlusIn & ~sysZeroMinusIn) : sysZeroMinusIn;
  // receive: data/zero format or plus/minus line copies
  assign sysPlusNext  = fmt_reg ? diffRxNext : usbDpIn;
  assign sysMinusNext = fmt_reg ? seZero : usbDmIn;

  // pin directions and levels, one register stage
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      sysDataPlusOut  <= 1'b0;
      sysDataPlusOe   <= 1'b0;
      sysZeroMinusOut <= 1'b0;
      sysZeroMinusOe  <= 1'b0;
      usbDpOut        <= 1'b0;
      usbDpOe         <= 1'b0;
      usbDmOut        <= 1'b0;
      usbDmOe         <= 1'b0;
      diffRxOut       <= 1'b0;
      plusLineCopy    <= 1'b0;
      minusLineCopy   <= 1'b0;
      fullSpeed       <= 1'b0;
      suspended       <= 1'b0;
    end else begin
      sysDataPlusOe   <= rxMode;
      sysZeroMinusOe  <= rxMode;
      sysDataPlusOut  <= rxMode & sysPlusNext;
      sysZeroMinusOut <= rxMode & sysMinusNext;
      // no line drive while suspended, to save power
      usbDpOe         <= ~rxMode & ~suspEff;
      usbDmOe         <= ~rxMode & ~suspEff;
      usbDpOut        <= ~rxMode & txDp;
      usbDmOut        <= ~rxMode & txDm;
      diffRxOut       <= diffRxNext;
      plusLineCopy    <= usbDpIn;
      minusLineCopy   <= usbDmIn;
      fullSpeed       <= speedEff;
      suspended       <= suspEff;
    end
  end

  assign statusWord = {{(APB_DW-6){1'b0}}, mgmtSclIn, irqPending, diffRxOut,
                       rxMode, suspended, fullSpeed};

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and management pins

  logic [NUM_PINS-1:0] pinEn, pinPp, pinReq, pinOutV, pinOeV;

  // the dedicated pin signals pending interrupts as a low level
  assign pinEn[PIN_INT]  = 1'b1;
  assign pinPp[PIN_INT]  = irqPp_reg;
  assign pinReq[PIN_INT] = irqPending;
  // direction pin mirrors the same conditions
  assign pinEn[PIN_DIR]  = dirAsIrq;
  assign pinPp[PIN_DIR]  = irqPp_reg;
  assign pinReq[PIN_DIR] = irqPending;
  // serial data line is always open-drain, never driven high
  assign pinEn[PIN_SDA]  = 1'b1;
  assign pinPp[PIN_SDA]  = 1'b0;
  assign pinReq[PIN_SDA] = mgmtPull_reg;

  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      uop_pin_drv u_drv (
        .clk       (clk),
        .arst      (arst),
        .enable    (pinEn[i]),
        .pushPull  (pinPp[i]),
        .assertReq (pinReq[i]),
        .pinOut    (pinOutV[i]),
        .pinOe     (pinOeV[i])
      );
    end
  endgenerate

  assign intPinOut  = pinOutV[PIN_INT];
  assign intPinOe   = pinOeV[PIN_INT];
  assign dirPinOut  = pinOutV[PIN_DIR];
  assign dirPinOe   = pinOeV[PIN_DIR];
  assign mgmtSdaOut = pinOutV[PIN_SDA];
  assign mgmtSdaOe  = pinOeV[PIN_SDA];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_dir_sys_out: assert property (@(posedge clk) disable iff (arst)
    dirPinIn |=> sysDataPlusOe && sysZeroMinusOe)
    else $error("system pins not outputs in receive mode");

  a_tx_usb_drive: assert property (@(posedge clk) disable iff (arst)
    !rxMode && !suspEff |=> usbDpOe && usbDmOe && !sysZeroMinusOe)
    else $error("transmit mode not driving usb lines");

  a_rx_follows_j: assert property (@(posedge clk) disable iff (arst)
    rxMode && !suspEff && usbDpIn && !usbDmIn |=> diffRxOut)
    else $error("receiver not high for D+ high D- low");

  a_rx_follows_k: assert property (@(posedge clk) disable iff (arst)
    rxMode && !suspEff && !usbDpIn && usbDmIn |=> !diffRxOut)
    else $error("receiver not low for D+ low D- high");

  a_rx_sleep_low: assert property (@(posedge clk) disable iff (arst)
    suspEff |=> !diffRxOut && suspended)
    else $error("receiver not low in suspend");

  a_fmt_se0_flag: assert property (@(posedge clk) disable iff (arst)
    rxMode && fmt_reg && !usbDpIn && !usbDmIn |=> sysZeroMinusOut)
    else $error("zero flag missing in data/zero format");

  a_ovr_regs_rule: assert property (@(posedge clk) disable iff (arst)
    ovr_reg |=> fullSpeed == $past(speed_reg) && suspended == $past(susp_reg))
    else $error("pins not ignored under override");

  a_pins_rule: assert property (@(posedge clk) disable iff (arst)
    !ovr_reg |=> fullSpeed == $past(rateSelPin) && suspended == $past(lowpowerPin))
    else $error("pins not governing without override");

  a_int_active_low: assert property (@(posedge clk) disable iff (arst)
    irqPending |=> intPinOe && !intPinOut)
    else $error("pending interrupt not shown low");

  a_dir_irq_mirror: assert property (@(posedge clk) disable iff (arst)
    dirAsIrq && irqPending |=> dirPinOe && !dirPinOut)
    else $error("direction pin not mirroring interrupt");

  a_dir_irq_off: assert property (@(posedge clk) disable iff (arst)
    !pinInt_reg |=> !dirPinOe)
    else $error("direction pin driven with its irq disabled");

  a_sda_low_only: assert property (@(posedge clk) disable iff (arst)
    mgmtSdaOe |-> !mgmtSdaOut)
    else $error("serial data line driven high");

endmodule

// *** uop_sys_partner.sv ***
/*
  model of the usb controller logic on the system side: drives the direction,
  rate and suspend pins and resolves the shared system data wires.
  assumes the bench sets what the controller wants on each pin.
*/
module uop_sys_partner (
  input  wire logic dirWant,   // 1 asks for receive
  input  wire logic plusWant,  // data/plus level sent
  input  wire logic minusWant, // zero/minus level sent
  input  wire logic fullWant,  // 1 full speed
  input  wire logic sleepWant, // 1 suspend
  input  wire logic dirOut,    // device level on direction pin
  input  wire logic dirOe,     // device drives direction pin
  input  wire logic plusOut,   // device level on data/plus
  input  wire logic plusOe,    // device drives data/plus
  input  wire logic minusOut,  // device level on zero/minus
  input  wire logic minusOe,   // device drives zero/minus
  output logic      dirLvl,    // resolved direction pin
  output logic      plusLvl,   // resolved data/plus
  output logic      minusLvl,  // resolved zero/minus
  output logic      rateSel,   // rate pin
  output logic      lowpower   // suspend pin
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////
  // the device's drive wins, so an interrupt level reaches the pin
  assign dirLvl   = dirOe ? dirOut : dirWant;
  assign plusLvl  = plusOe ? plusOut : plusWant;
  assign minusLvl = minusOe ? minusOut : minusWant;
  assign rateSel  = fullWant;
  assign lowpower = sleepWant;
endmodule

// *** tb_usb_otg_system_port_control.sv ***
/*
  self-checking bench of the port control block with an apb master.
  assumes one 40 MHz clock and pin outputs one clock behind their inputs.
*/
module tb_usb_otg_system_port_control import uop_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, resetPinN = 1'b1;   // clock and resets
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
  logic [11:0] paddr = 12'h000;                     // apb address
  logic [31:0] pwdata = 32'h0, prdata, rd;          // apb data
  logic pready, pslverr, er;                        // apb answer
  logic dirWant = 0, plusWant = 0, minusWant = 0, fullWant = 0, sleepWant = 0;
  logic dpDrv = 0, dmDrv = 0, irqPending = 0, mgmtSclIn = 1'b1; // far pins
  logic dirPinIn, dirPinOut, dirPinOe, sysDataPlusIn, sysDataPlusOut, sysDataPlusOe;
  logic sysZeroMinusIn, sysZeroMinusOut, sysZeroMinusOe, rateSelPin, lowpowerPin;
  logic usbDpIn, usbDpOut, usbDpOe, usbDmIn, usbDmOut, usbDmOe, diffRxOut;
  logic plusLineCopy, minusLineCopy, intPinOut, intPinOe, mgmtSdaOut, mgmtSdaOe;
  logic fullSpeed, suspended;                        // effective modes
  int   failures = 0, checks = 0;                    // tallies

  always #12.5 clk = ~clk;
  // usb lines resolved from the device drive and the cable side
  assign usbDpIn = usbDpOe ? usbDpOut : dpDrv;
  assign usbDmIn = usbDmOe ? usbDmOut : dmDrv;

  uop_port_ctrl uut (.clk, .rst, .resetPinN, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .dirPinIn, .dirPinOut, .dirPinOe, .sysDataPlusIn,
    .sysDataPlusOut, .sysDataPlusOe, .sysZeroMinusIn, .sysZeroMinusOut, .sysZeroMinusOe,
    .usbDpIn, .usbDpOut, .usbDpOe, .usbDmIn, .usbDmOut, .usbDmOe, .diffRxOut,
    .plusLineCopy, .minusLineCopy, .rateSelPin, .lowpowerPin, .irqPending, .intPinOut,
    .intPinOe, .mgmtSclIn, .mgmtSdaOut, .mgmtSdaOe, .fullSpeed, .suspended);
  uop_sys_partner ctl (.dirWant, .plusWant, .minusWant, .fullWant, .sleepWant,
    .dirOut(dirPinOut), .dirOe(dirPinOe), .plusOut(sysDataPlusOut), .plusOe(sysDataPlusOe),
    .minusOut(sysZeroMinusOut), .minusOe(sysZeroMinusOe), .dirLvl(dirPinIn),
    .plusLvl(sysDataPlusIn), .minusLvl(sysZeroMinusIn), .rateSel(rateSelPin),
    .lowpower(lowpowerPin));

  ////////////////////////////////////////////////////////////////////////////
  // compares and bus cycles
  task automatic chk1(input logic g, input logic e, input string m);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // one transfer; the wait is bounded since the slave sets the pace
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    chk1(n < 16, 1'b1, "no ready");
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // direction, plus, minus wanted by the controller, then D+ and D- of the cable
  task automatic pins(input logic [4:0] v);
    @(posedge clk);
    {dirWant, plusWant, minusWant, dpDrv, dmDrv} <= v;
    settle();
  endtask
  task automatic modes(input logic full, input logic sleep, input logic irq);
    @(posedge clk);
    {fullWant, sleepWant, irqPending} <= {full, sleep, irq};
    settle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_vals;
    logic [11:0] ofs [4];
    ofs = '{OFS_CTRL1, OFS_SFR1, OFS_SFR2, OFS_MGMT};
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      chk32(rd, 32'h0, "reset value");
    end
    apb(1'b0, 12'h020, 32'h0);
    chk1(er, 1'b1, "unmapped error");
  endtask
  task automatic t_direction;
    pins(5'b01000);
    chk1(sysZeroMinusOe, 1'b0, "minus pin input");
    chk1(usbDpOe, 1'b1, "transmit drives usb");
    chk1(usbDpOut, 1'b1, "d+ follows plus");
    pins(5'b10001);
    chk1(sysZeroMinusOe, 1'b1, "minus pin output");
    chk1(usbDpOe, 1'b0, "receive releases usb");
    chk1(sysZeroMinusOut, 1'b1, "minus follows d-");
    chk1(minusLineCopy, 1'b1, "d- copy");
  endtask
  task automatic t_format;
    apb(1'b1, OFS_CTRL1, 32'h4);
    pins(5'b00100);
    chk1(usbDpOut | usbDmOut, 1'b0, "zero state sent");
    pins(5'b00000);
    chk1(usbDmOut, 1'b1, "data zero sent");
    pins(5'b10000);
    chk1(sysZeroMinusOut, 1'b1, "zero state seen");
    pins(5'b10010);
    chk1(sysDataPlusOut, 1'b1, "receiver value seen");
    apb(1'b1, OFS_CTRL1, 32'h0);
  endtask
  task automatic t_diffrx;
    pins(5'b10010);
    chk1(diffRxOut, 1'b1, "rx high");
    chk1(plusLineCopy, 1'b1, "d+ copy");
    pins(5'b10001);
    chk1(diffRxOut, 1'b0, "rx low");
    pins(5'b10010);
    modes(1'b0, 1'b1, 1'b0);
    chk1(diffRxOut, 1'b0, "rx low in suspend");
    chk1(suspended, 1'b1, "suspend pin");
    modes(1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_override;
    apb(1'b1, OFS_CTRL1, 32'h3);
    modes(1'b1, 1'b0, 1'b0);
    chk1(fullSpeed, 1'b1, "rate pin full");
    chk1(suspended, 1'b0, "suspend bit ignored");
    modes(1'b0, 1'b0, 1'b0);
    chk1(fullSpeed, 1'b0, "speed bit ignored");
    apb(1'b1, OFS_SFR1, 32'h2);
    settle();
    chk1(fullSpeed, 1'b1, "speed bit rules");
    chk1(suspended, 1'b1, "suspend bit rules");
    apb(1'b1, OFS_CTRL1, 32'h0);
    modes(1'b1, 1'b1, 1'b0);
    chk1(fullSpeed, 1'b0, "rate pin ignored");
    chk1(suspended, 1'b0, "suspend pin ignored");
    apb(1'b1, OFS_SFR1, 32'h0);
    modes(1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_irq;
    modes(1'b0, 1'b0, 1'b1);
    chk1(intPinOe, 1'b1, "open drain pulls");
    chk1(intPinOut, 1'b0, "low active");
    modes(1'b0, 1'b0, 1'b0);
    chk1(intPinOe, 1'b0, "open drain released");
    apb(1'b1, OFS_SFR2, 32'h2);
    settle();
    chk1(intPinOe & intPinOut, 1'b1, "push pull idle high");
    modes(1'b0, 1'b1, 1'b1);
    chk1(intPinOut, 1'b0, "push pull low");
    chk1(dirPinOe, 1'b0, "pin irq disabled");
    apb(1'b1, OFS_CTRL1, 32'h20);
    settle();
    chk1(dirPinOe, 1'b1, "pin irq enabled");
    chk1(dirPinOut, 1'b0, "pin irq low");
    modes(1'b0, 1'b1, 1'b0);
    chk1(dirPinOut, 1'b1, "pin irq idle");
    modes(1'b0, 1'b0, 1'b0);
    chk1(dirPinOe, 1'b0, "awake releases pin");
    apb(1'b1, OFS_CTRL1, 32'h0);
    apb(1'b1, OFS_SFR2, 32'h0);
  endtask
  task automatic t_mgmt;
    apb(1'b1, OFS_MGMT, 32'h1);
    settle();
    chk1(mgmtSdaOe, 1'b1, "data line pulled");
    chk1(mgmtSdaOut, 1'b0, "never driven high");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk1(rd[ST_SCL], 1'b1, "clock level seen");
    mgmtSclIn <= 1'b0;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk1(rd[ST_SCL], 1'b0, "clock low seen");
    mgmtSclIn <= 1'b1;
    // async reset pin mid-run, checked before any further edge
    @(posedge clk);
    resetPinN <= 1'b0;
    #1;
    chk1(mgmtSdaOe, 1'b0, "async reset");
    @(posedge clk);
    resetPinN <= 1'b1;
    apb(1'b0, OFS_MGMT, 32'h0);
    chk32(rd, 32'h0, "reset cleared");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict, watchdog and main sequence
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200us;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_direction();
    t_format();
    t_diffrx();
    t_override();
    t_irq();
    t_mgmt();
    print_verdict();
  end
endmodule
